/* File: design/sra_core.sv */
// Purpose: address pointer, stack, window, bank, index and row pointer logic
// Assumes: sequencer inputs synchronous to CLOCK, one instruction per cycle
// Notes: soft resets are one-cycle pulses; window register has no reset
//        stack has no overflow check; software keeps pushes within the depth
//
// Operation
// - push decrements pointer, then stores address
// - pop loads address, then increments pointer
// - indirect branch jumps to held address
// - indirect call jumps to held address
// - small variant: 8-bit pointer wraps FF
// - large variant: 13-bit pointer wraps 1FFF
// - window register is 4 bits at 78H
// - window undefined at power-on, kept otherwise
// - file read copies entry into window
// - file write copies window into entry
// - bank register upper two bits zero
// - bank selects 0-3, cleared by resets
// - bank writable whatever bank is selected
// - index spans 7AH low bits, 7BH, 7CH
// - row pointer from 7AH/7BH, enable 7AH msb
// - row pointer shares index bits; 7AH b2,b1 zero
// - index and enables cleared by all resets
// - enabled index ORs into OP_DM data addresses, not OP_GR_IND
// - index ignored for non data-memory instructions
// - row pointer replaces indirect destination bank/row
// - index increment wraps at 1FFH
// - fixed-zero bits ignore writes, read zero
module sra_core #(
   parameter int AR_W = 13,
   parameter int IX_W = 9,
   parameter int STACK_DEPTH = 8
) (
   input wire logic CLOCK,
   input wire logic RST_N,
   input wire logic CLKSTOP_RST,
   input wire logic CE_RST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [sra_pkg::APB_AW-1:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic INSTR_VALID,
   input wire sra_pkg::sra_op_type INSTR_OP,
   input wire logic [sra_pkg::ROW_W-1:0] DM_ROW,
   input wire logic [sra_pkg::COL_W-1:0] DM_COL,
   input wire logic [sra_pkg::RF_AW-1:0] RF_ADDR_IN,
   input wire logic [sra_pkg::NIB_W-1:0] RF_RDATA,
   output logic PC_LOAD,
   output logic PC_CALL,
   output logic [AR_W-1:0] PC_TARGET,
   output logic RF_WE,
   output logic [sra_pkg::RF_AW-1:0] RF_ADDR,
   output logic [sra_pkg::NIB_W-1:0] RF_WDATA,
   output logic DM_VALID,
   output logic [sra_pkg::DM_AW-1:0] DM_ADDR
);
   import sra_pkg::*;

   localparam int SP_W = $clog2(STACK_DEPTH) + 1;
   localparam logic [SP_W-1:0] SP_EMPTY = SP_W'(STACK_DEPTH);
   localparam logic [SP_W-1:0] SP_ONE = SP_W'(1);
   localparam logic [AR_W-1:0] AR_ONE = AR_W'(1);
   localparam logic [AR_W-1:0] AR_RST = '0;
   localparam logic [IX_W-1:0] IX_ONE = IX_W'(1);

   logic [AR_W-1:0] ar_q;
   logic [AR_W-1:0] stack_q [STACK_DEPTH];
   logic [SP_W-1:0] sp_q;
   logic [NIB_W-1:0] window_q;
   logic [BANK_W-1:0] bank_q;
   logic row_en_q;
   logic ixh_q;
   logic [NIB_W-1:0] ixm_q;
   logic [NIB_W-1:0] ixl_q;
   logic ix_en_q;
   logic soft_rst;
   logic [7:0] idx;
   logic wr_acc;
   logic [DM_AW-1:0] ix_value;
   logic [ROWPTR_W-1:0] row_ptr;
   logic [IX_W-1:0] ix_inc;
   logic [DM_AW-1:0] ix_next;
   logic [DM_AW-1:0] dm_plain;
   logic [31:0] rd_d;
   logic hit_d;
   logic op_ok;
   logic [SP_W-1:0] sp_dec;
   logic [AR_W-1:0] stack_top;

   assign soft_rst = CLKSTOP_RST | CE_RST;
   assign idx = PADDR[IDX_SHIFT +: 8];
   assign wr_acc = PSEL & PENABLE & PREADY & PWRITE & ~PSLVERR;
   assign op_ok = INSTR_VALID;
   // upper index bits are the row pointer; 7AH b2,b1 are wired zero
   assign ix_value = {2'b00, ixh_q, ixm_q, ixl_q};
   assign row_ptr = {2'b00, ixh_q, ixm_q};
   assign ix_inc = ix_value[IX_W-1:0] + IX_ONE;
   assign ix_next = DM_AW'(ix_inc);
   assign dm_plain = {{(DM_BANK_W-BANK_W){1'b0}}, bank_q, DM_ROW, DM_COL};
   // one stack read port, shared by pop and its check
   assign sp_dec = sp_q - SP_ONE;
   assign stack_top = stack_q[sp_q[SP_W-2:0]];

   // read mux; only defined bits are returned, the rest read zero
   always_comb begin
      rd_d = '0;
      hit_d = 1'b1;
      case (idx)
         IDX_AR: rd_d = 32'(ar_q);
         IDX_WINDOW: rd_d = 32'(window_q);
         IDX_BANK: rd_d = 32'(bank_q);
         IDX_IXH: rd_d = {28'h0, row_en_q, 2'b00, ixh_q};
         IDX_IXM: rd_d = 32'(ixm_q);
         IDX_IXL: rd_d = 32'(ixl_q);
         IDX_FLAGS: rd_d = 32'(ix_en_q);
         IDX_STACK: rd_d = 32'(sp_q);
         default: hit_d = 1'b0;
      endcase
   end

   // zero-wait APB: answer in the first access cycle
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         PREADY <= 1'b0;
         PRDATA <= 32'h0;
         PSLVERR <= 1'b0;
      end else begin
         PREADY <= PSEL & ~PENABLE;
         if (PSEL & ~PENABLE) begin
            PRDATA <= PWRITE ? 32'h0 : rd_d;
            PSLVERR <= ~hit_d;
         end else if (PREADY) begin
            PRDATA <= 32'h0;
            PSLVERR <= 1'b0;
         end
      end
   end

   // address pointer and stack; instruction wins over a same-cycle bus write
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         ar_q <= AR_RST;
         sp_q <= SP_EMPTY;
      end else if (soft_rst) begin
         ar_q <= AR_RST;
      end else if (op_ok && INSTR_OP == OP_PUSH_AR) begin
         sp_q <= sp_dec;
      end else if (op_ok && INSTR_OP == OP_POP_AR) begin
         ar_q <= stack_top;
         sp_q <= sp_q + SP_ONE;
      end else if (op_ok && INSTR_OP == OP_INC_AR) begin
         ar_q <= ar_q + AR_ONE; // width sets the wrap point
      end else if (wr_acc && idx == IDX_AR) begin
         ar_q <= PWDATA[AR_W-1:0];
      end
   end

   // stack contents need no reset; entries are written before being popped
   always_ff @(posedge CLOCK) begin
      if (op_ok && INSTR_OP == OP_PUSH_AR && !soft_rst) begin
         stack_q[sp_dec[SP_W-2:0]] <= ar_q; // entry chosen by new pointer
      end
   end

   // window has no reset: undefined at power-on, then kept across every reset
   always_ff @(posedge CLOCK) begin
      if (op_ok && INSTR_OP == OP_FILE_READ_TO_WINDOW) begin
         window_q <= RF_RDATA;
      end else if (wr_acc && idx == IDX_WINDOW) begin
         window_q <= PWDATA[NIB_W-1:0];
      end
   end

   // bank register is always reachable, independent of the selected bank
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         bank_q <= BANK_RST;
      end else if (soft_rst) begin
         bank_q <= BANK_RST;
      end else if (wr_acc && idx == IDX_BANK) begin
         bank_q <= PWDATA[BANK_W-1:0]; // upper bits dropped
      end
   end

   // index, row pointer and both enables
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         row_en_q <= 1'b0;
         ixh_q <= 1'b0;
         ixm_q <= NIB_RST;
         ixl_q <= NIB_RST;
         ix_en_q <= 1'b0;
      end else if (soft_rst) begin
         row_en_q <= 1'b0;
         ixh_q <= 1'b0;
         ixm_q <= NIB_RST;
         ixl_q <= NIB_RST;
         ix_en_q <= 1'b0;
      end else if (op_ok && INSTR_OP == OP_INC_IX) begin
         ixh_q <= ix_next[2*NIB_W];
         ixm_q <= ix_next[NIB_W +: NIB_W];
         ixl_q <= ix_next[NIB_W-1:0];
      end else if (wr_acc) begin
         case (idx)
            IDX_IXH: begin
               row_en_q <= PWDATA[IXH_ROWEN_BIT];
               ixh_q <= PWDATA[IXH_DATA_BIT]; // b2,b1 ignored
            end
            IDX_IXM: ixm_q <= PWDATA[NIB_W-1:0];
            IDX_IXL: ixl_q <= PWDATA[NIB_W-1:0];
            IDX_FLAGS: ix_en_q <= PWDATA[FLAGS_IXEN_BIT];
            default: ;
         endcase
      end
   end

   // sequencer-facing results, one cycle after the instruction
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         PC_LOAD <= 1'b0;
         PC_CALL <= 1'b0;
         PC_TARGET <= AR_RST;
         RF_WE <= 1'b0;
         RF_ADDR <= '0;
         RF_WDATA <= NIB_RST;
         DM_VALID <= 1'b0;
         DM_ADDR <= '0;
      end else begin
         PC_LOAD <= op_ok && (INSTR_OP == OP_BR_AR || INSTR_OP == OP_CALL_AR);
         PC_CALL <= op_ok && INSTR_OP == OP_CALL_AR;
         PC_TARGET <= ar_q;
         RF_WE <= op_ok && INSTR_OP == OP_WINDOW_WRITE_TO_FILE;
         RF_ADDR <= RF_ADDR_IN;
         RF_WDATA <= window_q;
         DM_VALID <= op_ok && (INSTR_OP == OP_DM || INSTR_OP == OP_GR_IND);
         if (INSTR_OP == OP_DM && ix_en_q) begin
            DM_ADDR <= dm_plain | ix_value;
         end else if (INSTR_OP == OP_GR_IND && row_en_q) begin
            DM_ADDR <= {row_ptr, DM_COL};
         end else begin
            DM_ADDR <= dm_plain; // other instructions unmodified
         end
      end
   end

   // bank 3 on the small variant is a software fault, not checked here

   AST_PUSH_STORE: assert property (@(posedge CLOCK) disable iff (!RST_N)
      (op_ok && INSTR_OP == OP_PUSH_AR && !soft_rst) |=> sp_q == $past(sp_q) - SP_ONE
      && stack_q[sp_q[SP_W-2:0]] == $past(ar_q))
      else $error("push did not store address at decremented pointer");
   AST_POP_LOAD: assert property (@(posedge CLOCK) disable iff (!RST_N)
      (op_ok && INSTR_OP == OP_POP_AR && !soft_rst) |=> sp_q == $past(sp_q) + SP_ONE
      && ar_q == $past(stack_top))
      else $error("pop did not load address and increment pointer");
   AST_PUSH_POP: assert property (@(posedge CLOCK) disable iff (!RST_N || soft_rst)
      (op_ok && INSTR_OP == OP_PUSH_AR) ##1 (op_ok && INSTR_OP == OP_POP_AR) |=> ar_q == $past(ar_q, 2))
      else $error("pop after push did not restore address");
   AST_BRANCH: assert property (@(posedge CLOCK) disable iff (!RST_N)
      (op_ok && INSTR_OP == OP_BR_AR) |=> PC_LOAD && !PC_CALL && PC_TARGET == $past(ar_q))
      else $error("indirect branch target wrong");
   AST_CALL: assert property (@(posedge CLOCK) disable iff (!RST_N)
      (op_ok && INSTR_OP == OP_CALL_AR) |=> PC_LOAD && PC_CALL && PC_TARGET == $past(ar_q))
      else $error("indirect call target wrong");
   AST_AR_WRAP: assert property (@(posedge CLOCK) disable iff (!RST_N || soft_rst)
      (op_ok && INSTR_OP == OP_INC_AR && &ar_q) |=> ar_q == AR_RST)
      else $error("address pointer did not wrap to zero");
   AST_FILE_READ_TO_WINDOW: assert property (@(posedge CLOCK) disable iff (!RST_N)
      (op_ok && INSTR_OP == OP_FILE_READ_TO_WINDOW) |=> window_q == $past(RF_RDATA))
      else $error("file read did not load window");
   AST_WINDOW_WRITE_TO_FILE: assert property (@(posedge CLOCK) disable iff (!RST_N)
      (op_ok && INSTR_OP == OP_WINDOW_WRITE_TO_FILE) |=> RF_WE && RF_WDATA == $past(window_q))
      else $error("file write data wrong");
   AST_SOFT_CLEAR: assert property (@(posedge CLOCK) disable iff (!RST_N)
      soft_rst |=> bank_q == BANK_RST && ix_value == '0 && !row_en_q && !ix_en_q)
      else $error("soft reset did not clear bank and index");
   AST_WINDOW_HOLD: assert property (@(posedge CLOCK) disable iff (!RST_N)
      (soft_rst && !(op_ok && INSTR_OP == OP_FILE_READ_TO_WINDOW) && !(wr_acc && idx == IDX_WINDOW))
      |=> window_q == $past(window_q))
      else $error("window changed on soft reset");
   AST_IX_OR: assert property (@(posedge CLOCK) disable iff (!RST_N)
      (op_ok && INSTR_OP == OP_DM && ix_en_q) |=> DM_VALID && DM_ADDR == ($past(dm_plain) | $past(ix_value)))
      else $error("index modification wrong");
   AST_ROW_PTR: assert property (@(posedge CLOCK) disable iff (!RST_N)
      (op_ok && INSTR_OP == OP_GR_IND && row_en_q) |=> DM_ADDR == {$past(row_ptr), $past(DM_COL)})
      else $error("row pointer replacement wrong");
   AST_IX_WRAP: assert property (@(posedge CLOCK) disable iff (!RST_N || soft_rst)
      (op_ok && INSTR_OP == OP_INC_IX && ix_value[IX_W-1:0] == '1) |=> ix_value == '0)
      else $error("index did not wrap to zero");
   AST_ZERO_BITS: assert property (@(posedge CLOCK) disable iff (!RST_N)
      (PREADY && PSEL && !PWRITE && idx == IDX_IXH) |-> PRDATA[2:1] == 2'b00)
      else $error("fixed-zero bits read non-zero");

   // bus writes; a same-cycle soft reset or instruction has priority, so those cycles are left out, except OP_INC_IX in AST_IX_EN_WRITE
   AST_BANK_WRITE: assert property (@(posedge CLOCK) disable iff (!RST_N)
      (wr_acc && idx == IDX_BANK && !soft_rst)
      |=> bank_q == BANK_W'($past(PWDATA)))
      else $error("bank write not taken");
   AST_BANK_READ: assert property (@(posedge CLOCK) disable iff (!RST_N)
      (PREADY && PSEL && !PWRITE && idx == IDX_BANK)
      |-> PRDATA[31:BANK_W] == '0)
      else $error("bank upper bits read non-zero");
   AST_WINDOW_WRITE: assert property (@(posedge CLOCK) disable iff (!RST_N)
      (wr_acc && idx == IDX_WINDOW && !(op_ok && INSTR_OP == OP_FILE_READ_TO_WINDOW))
      |=> window_q == NIB_W'($past(PWDATA)))
      else $error("window write not taken");
   AST_IX_EN_WRITE: assert property (@(posedge CLOCK) disable iff (!RST_N)
      (wr_acc && idx == IDX_FLAGS && !soft_rst)
      |=> ix_en_q == $past(PWDATA[FLAGS_IXEN_BIT]))
      else $error("index enable write not taken");
   AST_ROW_EN_WRITE: assert property (@(posedge CLOCK) disable iff (!RST_N)
      (wr_acc && idx == IDX_IXH && !soft_rst && !(op_ok && INSTR_OP == OP_INC_IX))
      |=> row_en_q == $past(PWDATA[IXH_ROWEN_BIT]) && ixh_q == $past(PWDATA[IXH_DATA_BIT]))
      else $error("row pointer enable write not taken");
   AST_IXM_WRITE: assert property (@(posedge CLOCK) disable iff (!RST_N)
      (wr_acc && idx == IDX_IXM && !soft_rst && !(op_ok && INSTR_OP == OP_INC_IX))
      |=> ixm_q == NIB_W'($past(PWDATA)))
      else $error("index mid nibble write not taken");
   AST_IXL_WRITE: assert property (@(posedge CLOCK) disable iff (!RST_N)
      (wr_acc && idx == IDX_IXL && !soft_rst && !(op_ok && INSTR_OP == OP_INC_IX))
      |=> ixl_q == NIB_W'($past(PWDATA)))
      else $error("index low nibble write not taken");

   // instruction side effects
   AST_AR_INC: assert property (@(posedge CLOCK) disable iff (!RST_N)
      (op_ok && INSTR_OP == OP_INC_AR && !soft_rst)
      |=> ar_q == $past(ar_q) + AR_ONE)
      else $error("address pointer did not increment");
   AST_IX_INC: assert property (@(posedge CLOCK) disable iff (!RST_N)
      (op_ok && INSTR_OP == OP_INC_IX && !soft_rst)
      |=> ix_value[IX_W-1:0] == IX_W'($past(ix_value)) + IX_ONE)
      else $error("index did not increment");
   AST_DM_PLAIN: assert property (@(posedge CLOCK) disable iff (!RST_N)
      (op_ok && INSTR_OP == OP_DM && !ix_en_q)
      |=> DM_VALID && DM_ADDR == $past(dm_plain))
      else $error("data address modified with index disabled");
   AST_NOT_DM: assert property (@(posedge CLOCK) disable iff (!RST_N)
      (op_ok && INSTR_OP != OP_DM && INSTR_OP != OP_GR_IND)
      |=> !DM_VALID)
      else $error("data access raised by non data-memory instruction");
   AST_NOP_QUIET: assert property (@(posedge CLOCK) disable iff (!RST_N)
      (op_ok && INSTR_OP == OP_NOP)
      |=> !PC_LOAD && !RF_WE && !DM_VALID)
      else $error("no-op produced an action");
   AST_PC_QUIET: assert property (@(posedge CLOCK) disable iff (!RST_N)
      (op_ok && INSTR_OP != OP_BR_AR && INSTR_OP != OP_CALL_AR)
      |=> !PC_LOAD)
      else $error("program counter load without branch or call");
   AST_WINDOW_WRITE_TO_FILE_ADDR: assert property (@(posedge CLOCK) disable iff (!RST_N)
      (op_ok && INSTR_OP == OP_WINDOW_WRITE_TO_FILE)
      |=> RF_ADDR == $past(RF_ADDR_IN))
      else $error("file write address wrong");
   AST_WINDOW_WINDOW_WRITE_TO_FILE: assert property (@(posedge CLOCK) disable iff (!RST_N)
      (op_ok && INSTR_OP == OP_WINDOW_WRITE_TO_FILE && !(wr_acc && idx == IDX_WINDOW))
      |=> window_q == $past(window_q))
      else $error("file write changed window");

   COV_PUSH_POP: cover property (@(posedge CLOCK) disable iff (!RST_N)
      (op_ok && INSTR_OP == OP_PUSH_AR) ##[1:4] (op_ok && INSTR_OP == OP_POP_AR));
   COV_IX_MOD: cover property (@(posedge CLOCK) disable iff (!RST_N)
      op_ok && INSTR_OP == OP_DM && ix_en_q);
   COV_ROW_MOD: cover property (@(posedge CLOCK) disable iff (!RST_N)
      op_ok && INSTR_OP == OP_GR_IND && row_en_q);
   COV_BANK_WR: cover property (@(posedge CLOCK) disable iff (!RST_N)
      wr_acc && idx == IDX_BANK);
   COV_SOFT_RST: cover property (@(posedge CLOCK) disable iff (!RST_N)
      soft_rst && row_en_q);
endmodule : sra_core

/* File: design/sra_pkg.sv */
// Purpose: shared constants and types for the address-related system registers
// Assumes: 32-bit APB, byte address = 4 * printed register index
// Notes: nibble-wide registers sit in the low bits of each word
package sra_pkg;
   localparam int APB_AW = 12;
   localparam int NIB_W = 4;
   // printed system-register indexes
   localparam logic [7:0] IDX_AR = 8'h74;
   localparam logic [7:0] IDX_WINDOW = 8'h78;
   localparam logic [7:0] IDX_BANK = 8'h79;
   localparam logic [7:0] IDX_IXH = 8'h7a;
   localparam logic [7:0] IDX_IXM = 8'h7b;
   localparam logic [7:0] IDX_IXL = 8'h7c;
   localparam logic [7:0] IDX_FLAGS = 8'h7f;
   localparam logic [7:0] IDX_STACK = 8'h80;
   localparam int IDX_SHIFT = 2;
   // field positions
   localparam int IXH_ROWEN_BIT = 3;
   localparam int IXH_DATA_BIT = 0;
   localparam int FLAGS_IXEN_BIT = 0;
   localparam int BANK_W = 2;
   localparam int ROW_W = 3;
   localparam int COL_W = 4;
   localparam int DM_BANK_W = 4;
   localparam int DM_AW = 11;
   localparam int ROWPTR_W = 7;
   localparam int RF_AW = 7;
   localparam logic [BANK_W-1:0] BANK_RST = 2'h0;
   localparam logic [NIB_W-1:0] NIB_RST = 4'h0;

   typedef enum logic [3:0] {
      OP_NOP = 4'b0000,
      OP_PUSH_AR = 4'b0001,
      OP_POP_AR = 4'b0010,
      OP_BR_AR = 4'b0011,
      OP_CALL_AR = 4'b0100,
      OP_INC_AR = 4'b0101,
      OP_INC_IX = 4'b0110,
      OP_FILE_READ_TO_WINDOW = 4'b0111,
      OP_WINDOW_WRITE_TO_FILE = 4'b1000,
      OP_DM = 4'b1001,
      OP_GR_IND = 4'b1010
   } sra_op_type;
endpackage : sra_pkg

/* File: verif/test_system_register_addressing.sv */
// Purpose: self-checking bench for the address-related system registers
// Assumes: zero-wait APB slave, sequencer outputs registered one cycle after the strobe
// Notes: large variant only; small-variant wrap is left to the design's own assertions
module test_system_register_addressing;
   timeunit 1ns;
   timeprecision 1ps;
   import sra_pkg::*;
   logic clock, rst_n, clkstop_rst, ce_rst, psel, penable, pwrite, pready, pslverr, er;
   logic instr_valid, pc_load, pc_call, rf_we, dm_valid;
   logic [APB_AW-1:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   sra_op_type instr_op;
   logic [ROW_W-1:0] dm_row;
   logic [COL_W-1:0] dm_col;
   logic [RF_AW-1:0] rf_addr_in, rf_addr;
   logic [NIB_W-1:0] rf_rdata, rf_wdata;
   logic [12:0] pc_target;
   logic [DM_AW-1:0] dm_addr;
   int error_cnt, cmp_count, cyc;

   sra_core #(.AR_W(13), .IX_W(9), .STACK_DEPTH(8)) u_dut (
      .CLOCK(clock), .RST_N(rst_n), .CLKSTOP_RST(clkstop_rst), .CE_RST(ce_rst),
      .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
      .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .INSTR_VALID(instr_valid), .INSTR_OP(instr_op), .DM_ROW(dm_row), .DM_COL(dm_col),
      .RF_ADDR_IN(rf_addr_in), .RF_RDATA(rf_rdata), .PC_LOAD(pc_load), .PC_CALL(pc_call),
      .PC_TARGET(pc_target), .RF_WE(rf_we), .RF_ADDR(rf_addr), .RF_WDATA(rf_wdata),
      .DM_VALID(dm_valid), .DM_ADDR(dm_addr));

   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   task automatic stop_test;
      $display("comparisons %0d, mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : stop_test

   // hang guard: the whole sequence needs well under 1000 cycles
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         error_cnt++;
         stop_test();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
      end
   endtask : chk

   // request held until the edge that samples pready high; data and error taken at that edge
   task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clock);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      @(posedge clock);
      while (pready !== 1'b1) begin
         @(posedge clock);
         n++;
      end
      rd = prdata;
      er = pslverr;
      chk(n, 32'h0, "apb wait states");
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [7:0] idx, input logic [31:0] d);
      apb(1'b1, idx, d);
   endtask : wr

   task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
      apb(1'b0, idx, 32'h0);
      chk(rd, exp, "register read");
      chk({31'h0, er}, 32'h0, "read error");
   endtask : rdchk

   // one instruction strobe; returns at the edge after the one that registers its outputs
   task automatic op(input sra_op_type o, input logic [2:0] r = 3'h0, input logic [3:0] c = 4'h0,
                     input logic [6:0] fa = 7'h00, input logic [3:0] fd = 4'h0);
      @(posedge clock);
      instr_valid <= 1'b1;
      instr_op <= o;
      dm_row <= r;
      dm_col <= c;
      rf_addr_in <= fa;
      rf_rdata <= fd;
      @(posedge clock);
      instr_valid <= 1'b0;
      @(posedge clock);
   endtask : op

   initial begin
      {rst_n, clkstop_rst, ce_rst, psel, penable, pwrite, instr_valid} = '0;
      paddr = '0;
      pwdata = '0;
      instr_op = OP_NOP;
      {dm_row, dm_col, rf_addr_in, rf_rdata} = '0;
      error_cnt = 0;
      cmp_count = 0;
      cyc = 0;
      repeat (8) @(posedge clock);
      rst_n <= 1'b1;
      rdchk(IDX_BANK, 32'h0);
      rdchk(IDX_IXH, 32'h0);
      rdchk(IDX_IXM, 32'h0);
      rdchk(IDX_IXL, 32'h0);
      rdchk(IDX_FLAGS, 32'h0);
      rdchk(IDX_STACK, 32'h8);
      apb(1'b0, 8'h10, 32'h0);
      chk({31'h0, er}, 32'h1, "unmapped error");
      wr(IDX_BANK, 32'hffff_ffff);
      rdchk(IDX_BANK, 32'h3);
      // starts with bank 3 selected, so each bank is selected at some rewrite
      // large variant only, where bank 3 exists
      for (int b = 0; b < 4; b++) begin
         wr(IDX_BANK, b);
         rdchk(IDX_BANK, b);
      end
      wr(IDX_WINDOW, 32'h5);
      rdchk(IDX_WINDOW, 32'h5);
      op(OP_WINDOW_WRITE_TO_FILE, 3'h0, 4'h0, 7'h2a);
      chk({rf_we, rf_addr, rf_wdata}, {1'b1, 7'h2a, 4'h5}, "file write");
      op(OP_FILE_READ_TO_WINDOW, 3'h0, 4'h0, 7'h11, 4'ha);
      rdchk(IDX_WINDOW, 32'ha);
      wr(IDX_IXH, 32'hf);
      rdchk(IDX_IXH, 32'h9);
      wr(IDX_IXM, 32'hf);
      wr(IDX_IXL, 32'hf);
      op(OP_INC_IX);
      rdchk(IDX_IXH, 32'h8);
      rdchk(IDX_IXM, 32'h0);
      rdchk(IDX_IXL, 32'h0);
      wr(IDX_IXH, 32'h9);
      wr(IDX_IXM, 32'h6);
      op(OP_GR_IND, 3'h1, 4'hc);
      chk({dm_valid, dm_addr}, {1'b1, 7'h16, 4'hc}, "row pointer");
      op(OP_DM, 3'h1, 4'hc);
      chk({dm_valid, dm_addr}, {1'b1, 4'h3, 3'h1, 4'hc}, "plain access");
      wr(IDX_IXL, 32'h5);
      wr(IDX_FLAGS, 32'h1);
      rdchk(IDX_FLAGS, 32'h1);
      op(OP_DM, 3'h1, 4'h8);
      chk({dm_valid, dm_addr}, {1'b1, {4'h3, 3'h1, 4'h8} | {3'h1, 4'h6, 4'h5}}, "indexed");
      op(OP_WINDOW_WRITE_TO_FILE, 3'h0, 4'h0, 7'h20);
      chk({rf_we, rf_addr}, {1'b1, 7'h20}, "file address");
      op(OP_NOP);
      chk({pc_load, rf_we, dm_valid}, 32'h0, "no-op");
      wr(IDX_AR, 32'h1ffe);
      op(OP_INC_AR);
      rdchk(IDX_AR, 32'h1fff);
      op(OP_INC_AR);
      rdchk(IDX_AR, 32'h0);
      wr(IDX_AR, 32'h123);
      op(OP_PUSH_AR);
      rdchk(IDX_STACK, 32'h7);
      wr(IDX_AR, 32'h456);
      op(OP_PUSH_AR);
      rdchk(IDX_STACK, 32'h6);
      wr(IDX_AR, 32'h0);
      op(OP_POP_AR);
      rdchk(IDX_AR, 32'h456);
      rdchk(IDX_STACK, 32'h7);
      op(OP_POP_AR);
      rdchk(IDX_AR, 32'h123);
      rdchk(IDX_STACK, 32'h8);
      wr(IDX_AR, 32'habc);
      op(OP_BR_AR);
      chk({pc_load, pc_call, pc_target}, {1'b1, 1'b0, 13'habc}, "branch");
      op(OP_CALL_AR);
      chk({pc_load, pc_call, pc_target}, {1'b1, 1'b1, 13'habc}, "call");
      // push then pop on consecutive cycles hands the address straight back
      @(posedge clock);
      instr_valid <= 1'b1;
      instr_op <= OP_PUSH_AR;
      @(posedge clock);
      instr_op <= OP_POP_AR;
      @(posedge clock);
      instr_valid <= 1'b0;
      rdchk(IDX_AR, 32'habc);
      rdchk(IDX_STACK, 32'h8);
      // clock-stop first, then chip-enable; window must survive both
      for (int k = 0; k < 2; k++) begin
         wr(IDX_BANK, 32'h2);
         wr(IDX_IXH, 32'h9);
         wr(IDX_FLAGS, 32'h1);
         @(posedge clock);
         if (k == 0) clkstop_rst <= 1'b1;
         else ce_rst <= 1'b1;
         @(posedge clock);
         clkstop_rst <= 1'b0;
         ce_rst <= 1'b0;
         rdchk(IDX_BANK, 32'h0);
         rdchk(IDX_IXH, 32'h0);
         rdchk(IDX_FLAGS, 32'h0);
         rdchk(IDX_WINDOW, 32'ha);
      end
      stop_test();
   end
endmodule : test_system_register_addressing
